// ==== odl_map.svh ====
// Purpose: Constants for the octal DAC serial load port, both ends
// Assumes: Included by bare name from the package, both port files and the bench
// Notes:   Timing counts are in cycles of the 100 MHz system clock
// Function
// - Rising serial clock shifts serial_in, twelve stages
// - First four bits address, MSB first
// - Next eight bits channel code, MSB first
// - Host strobes load only after twelve edges
// - Load high, clock low copies code
// - Decoded address loads only matching channel
// - Last stage drives serial_out, twelve-clock delay
// - Address 0001 selects channel A
// - Address 0000 changes no channel
// - Addresses 1001 to 1111 change no channel
// - Cascade: shared load, no-op addresses elsewhere
// - Preset low forces all codes to 80 hex
// - Clock and load low: everything holds
`ifndef ODL_MAP_SVH
`define ODL_MAP_SVH

`define ODL_FRAME_BITS   12
`define ODL_ADDR_BITS    4
`define ODL_CODE_BITS    8
`define ODL_CHANNELS     8
`define ODL_ADDR_MSB     11
`define ODL_ADDR_LSB     8
`define ODL_CODE_MSB     7
`define ODL_CODE_LSB     0
`define ODL_ADDR_FIRST   4'h1
`define ODL_ADDR_LAST    4'h8
`define ODL_PRESET_CODE  8'h80
`define ODL_SCLK_HALF    3
`define ODL_LOAD_CYC     4
`define ODL_GAP_CYC      4

`endif

// ==== odl_pkg.sv ====
// Purpose: Types shared by both ends of the serial load port
// Assumes: odl_map.svh supplies the widths
// Notes:   Constants live in the header, types live here
`include "odl_map.svh"
package odl_pkg;
  typedef logic [`ODL_FRAME_BITS-1:0] odl_frame_t;
  typedef logic [`ODL_ADDR_BITS-1:0]  odl_addr_t;
  typedef logic [`ODL_CODE_BITS-1:0]  odl_code_t;
  typedef logic [2:0]                 odl_chan_t;
  typedef odl_code_t [`ODL_CHANNELS-1:0] odl_codes_t;
endpackage

// ==== odl_link_if.sv ====
// Purpose: Serial load link between host and octal DAC
// Assumes: Host makes the serial clock and all strobes
// Notes:   Every wire has one driver, so no enables are needed
`timescale 1ns/10ps
interface odl_link_if;
  logic sclk;
  logic serial_in;
  logic load_strobe;
  logic preset_n;
  logic serial_out;

  modport dev
  (
    input  sclk,
    input  serial_in,
    input  load_strobe,
    input  preset_n,
    output serial_out
  );

  modport host
  (
    output sclk,
    output serial_in,
    output load_strobe,
    output preset_n,
    input  serial_out
  );
endinterface

// ==== odl_dac_port.sv ====
// Purpose: Device end: shift register on serial clock, eight code registers
// Assumes: Host changes serial_in, load_strobe and preset_n only while sclk is low
// Notes:   Load strobe is caught in the i_clk domain; the shift word is stable then
`timescale 1ns/10ps
`include "odl_map.svh"
module odl_dac_port
(
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  odl_link_if.dev                 link,
  output logic                    [`ODL_CODE_BITS*`ODL_CHANNELS-1:0] o_codes,
  output logic                    o_update,
  output odl_pkg::odl_chan_t      o_update_chan,
  output logic                    o_nop,
  output odl_pkg::odl_addr_t      o_last_addr
);
  import odl_pkg::*;

  // Channel number of an address; meaningful only for addresses A to H
  function automatic odl_chan_t chan_idx(input odl_addr_t addr);
    return 3'(addr - `ODL_ADDR_FIRST);
  endfunction

  // Decodes a frame address to a one-hot channel select, zero for no-op codes
  function automatic logic [`ODL_CHANNELS-1:0] chan_sel(input odl_addr_t addr);
    logic [`ODL_CHANNELS-1:0] sel;
    sel = '0;
    if (addr >= `ODL_ADDR_FIRST && addr <= `ODL_ADDR_LAST)
    begin
      sel[chan_idx(addr)] = 1'b1;
    end
    return sel;
  endfunction

  // Link domain: twelve-stage shift register clocked by the serial clock

  odl_frame_t shift_q;
  odl_frame_t shift_d;

  always_comb
  begin
    shift_d = shift_q;
    if (!link.load_strobe && link.preset_n)
    begin
      shift_d = {shift_q[`ODL_FRAME_BITS-2:0], link.serial_in};
    end
  end

  always_ff @(posedge link.sclk)
  begin
    shift_q <= shift_d;
  end

  // Last stage straight to the pin; a bit returns twelve edges later
  assign link.serial_out = shift_q[`ODL_FRAME_BITS-1];

  // System domain: load strobe synchroniser and edge capture

  logic load_s1_q;
  logic load_s2_q;
  logic load_s1_d;
  logic load_s2_d;

  always_comb
  begin
    load_s1_d = link.load_strobe;
    load_s2_d = load_s1_q;
    if (!i_rst_b)
    begin
      load_s1_d = 1'b0;
      load_s2_d = 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    load_s1_q <= load_s1_d;
    load_s2_q <= load_s2_d;
  end

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b01,
    ST_HELD = 2'b10
  } odl_ld_state_t;

  odl_ld_state_t state_q;
  odl_ld_state_t state_d;
  logic          take;
  logic          upd_q;
  logic          upd_d;
  logic          nop_q;
  logic          nop_d;
  odl_chan_t     uch_q;
  odl_chan_t     uch_d;
  odl_addr_t     addr_q;
  odl_addr_t     addr_d;
  odl_addr_t     f_addr;
  odl_code_t     f_code;
  logic [`ODL_CHANNELS-1:0] f_sel;

  // Sclk is low and the word is frozen while the strobe is high
  assign f_addr = shift_q[`ODL_ADDR_MSB:`ODL_ADDR_LSB];
  assign f_code = shift_q[`ODL_CODE_MSB:`ODL_CODE_LSB];
  assign f_sel  = chan_sel(f_addr);

  always_comb
  begin
    state_d = state_q;
    take    = 1'b0;
    upd_d   = 1'b0;
    nop_d   = 1'b0;
    uch_d   = uch_q;
    addr_d  = addr_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (load_s2_q)
        begin
          take    = 1'b1;
          state_d = ST_HELD;
          addr_d  = f_addr;
          upd_d   = |f_sel;
          nop_d   = ~|f_sel;
          if (|f_sel)
          begin
            uch_d = chan_idx(f_addr);
          end
        end
      end
      ST_HELD:
      begin
        if (!load_s2_q)
        begin
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (!i_rst_b)
    begin
      state_d = ST_IDLE;
      upd_d   = 1'b0;
      nop_d   = 1'b0;
      uch_d   = '0;
      addr_d  = '0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    state_q <= state_d;
    upd_q   <= upd_d;
    nop_q   <= nop_d;
    uch_q   <= uch_d;
    addr_q  <= addr_d;
  end

  assign o_update      = upd_q;
  assign o_nop         = nop_q;
  assign o_update_chan = uch_q;
  assign o_last_addr   = addr_q;

  // Preset enters at once but leaves only after two clocks, so no code register
  // sees a release edge that is close to its own clock edge
  logic pre_s1_q;
  logic pre_s2_q;
  logic pre_s1_d;
  logic pre_s2_d;

  always_comb
  begin
    pre_s1_d = 1'b1;
    pre_s2_d = pre_s1_q;
  end

  always_ff @(posedge i_clk or negedge link.preset_n)
  begin
    if (!link.preset_n)
    begin
      pre_s1_q <= 1'b0;
      pre_s2_q <= 1'b0;
    end
    else
    begin
      pre_s1_q <= pre_s1_d;
      pre_s2_q <= pre_s2_d;
    end
  end

  // Channel holding registers, preset asynchronously to mid-scale

  odl_codes_t hold_q;
  odl_codes_t hold_d;

  genvar ch;
  generate
    for (ch = 0; ch < `ODL_CHANNELS; ch++)
    begin : g_chan
      always_comb
      begin
        hold_d[ch] = hold_q[ch];
        if (take && f_sel[ch])
        begin
          hold_d[ch] = f_code;
        end
      end

      always_ff @(posedge i_clk or negedge pre_s2_q)
      begin
        if (!pre_s2_q)
        begin
          hold_q[ch] <= `ODL_PRESET_CODE;
        end
        else
        begin
          hold_q[ch] <= hold_d[ch];
        end
      end

      assign o_codes[ch*`ODL_CODE_BITS +: `ODL_CODE_BITS] = hold_q[ch];
    end
  endgenerate

endmodule // odl_dac_port

// ==== odl_host_port.sv ====
// Purpose: Host end: sends one address/code frame, strobes load, reads echo
// Assumes: Serial clock derived from i_clk by a divider
// Notes:   Shared load strobe suits cascades when other parts get no-op frames
`timescale 1ns/10ps
`include "odl_map.svh"
module odl_host_port
(
  input  wire logic               i_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_req,
  input  odl_pkg::odl_addr_t      i_addr,
  input  odl_pkg::odl_code_t      i_code,
  input  wire logic               i_preset,
  odl_link_if.host                link,
  output logic                    o_busy,
  output logic                    o_done,
  output odl_pkg::odl_frame_t     o_echo
);
  import odl_pkg::*;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'b00001,
    ST_LOW  = 5'b00010,
    ST_HIGH = 5'b00100,
    ST_LOAD = 5'b01000,
    ST_GAP  = 5'b10000
  } odl_hs_state_t;

  odl_hs_state_t state_q;
  odl_hs_state_t state_d;
  odl_frame_t    word_q;
  odl_frame_t    word_d;
  odl_frame_t    echo_q;
  odl_frame_t    echo_d;
  logic [3:0]    bit_q;
  logic [3:0]    bit_d;
  logic [2:0]    cnt_q;
  logic [2:0]    cnt_d;
  logic          sclk_q;
  logic          sclk_d;
  logic          sdi_q;
  logic          sdi_d;
  logic          load_q;
  logic          load_d;
  logic          pre_q;
  logic          pre_d;
  logic          done_q;
  logic          done_d;
  logic          busy_q;
  logic          busy_d;
  logic          so_s1_q;
  logic          so_s2_q;

  always_comb
  begin
    state_d = state_q;
    word_d  = word_q;
    echo_d  = echo_q;
    bit_d   = bit_q;
    cnt_d   = cnt_q + 3'h1;
    sclk_d  = sclk_q;
    sdi_d   = sdi_q;
    load_d  = load_q;
    done_d  = 1'b0;
    pre_d   = ~i_preset;
    unique case (state_q)
      ST_IDLE:
      begin
        cnt_d = '0;
        if (i_req)
        begin
          word_d  = {i_addr, i_code};
          sdi_d   = i_addr[`ODL_ADDR_BITS-1];
          bit_d   = '0;
          state_d = ST_LOW;
        end
      end
      ST_LOW:
      begin
        if (cnt_q == 3'(`ODL_SCLK_HALF - 1))
        begin
          echo_d  = {echo_q[`ODL_FRAME_BITS-2:0], so_s2_q};
          sclk_d  = 1'b1;
          cnt_d   = '0;
          state_d = ST_HIGH;
        end
      end
      ST_HIGH:
      begin
        if (cnt_q == 3'(`ODL_SCLK_HALF - 1))
        begin
          sclk_d = 1'b0;
          cnt_d  = '0;
          if (bit_q == 4'(`ODL_FRAME_BITS - 1))
          begin
            load_d  = 1'b1;
            state_d = ST_LOAD;
          end
          else
          begin
            bit_d   = bit_q + 4'h1;
            sdi_d   = word_q[4'(`ODL_FRAME_BITS - 2) - bit_q];
            state_d = ST_LOW;
          end
        end
      end
      ST_LOAD:
      begin
        if (cnt_q == 3'(`ODL_LOAD_CYC - 1))
        begin
          load_d  = 1'b0;
          cnt_d   = '0;
          state_d = ST_GAP;
        end
      end
      ST_GAP:
      begin
        if (cnt_q == 3'(`ODL_GAP_CYC - 1))
        begin
          done_d  = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (!i_rst_b)
    begin
      state_d = ST_IDLE;
      word_d  = '0;
      echo_d  = '0;
      bit_d   = '0;
      cnt_d   = '0;
      sclk_d  = 1'b0;
      sdi_d   = 1'b0;
      load_d  = 1'b0;
      done_d  = 1'b0;
      pre_d   = 1'b0;
    end
    busy_d = (state_d != ST_IDLE);
  end

  always_ff @(posedge i_clk)
  begin
    state_q <= state_d;
    word_q  <= word_d;
    echo_q  <= echo_d;
    bit_q   <= bit_d;
    cnt_q   <= cnt_d;
    sclk_q  <= sclk_d;
    sdi_q   <= sdi_d;
    load_q  <= load_d;
    pre_q   <= pre_d;
    done_q  <= done_d;
    busy_q  <= busy_d;
    so_s1_q <= link.serial_out;
    so_s2_q <= so_s1_q;
  end

  assign link.sclk        = sclk_q;
  assign link.serial_in   = sdi_q;
  assign link.load_strobe = load_q;
  assign link.preset_n    = pre_q;
  assign o_busy           = busy_q;
  assign o_done           = done_q;
  assign o_echo           = echo_q;

endmodule // odl_host_port

// ==== odl_link_properties.sv ====
// Purpose: Timing checks on the serial load link between the two ends
// Assumes: Host divides i_clk to make sclk; link pins change while sclk is low
// Notes:   Watches link wires only; both parties are design modules
`timescale 1ns/10ps
module odl_link_properties
(
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic sclk,
  input  wire logic serial_in,
  input  wire logic load_strobe,
  input  wire logic preset_n,
  input  wire logic serial_out
);
  logic [3:0] rise_q;
  logic [3:0] rise_d;
  logic       sclk_q;
  logic [3:0] fill_q;
  logic [3:0] fill_d;

  // Serial clock rises since the last load strobe
  always_comb
  begin
    rise_d = rise_q;
    if (sclk && !sclk_q)
      rise_d = rise_q + 4'h1;
    if (load_strobe)
      rise_d = 4'h0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_b)
    begin
      rise_q <= 4'h0;
      sclk_q <= 1'b0;
    end
    else
    begin
      rise_q <= rise_d;
      sclk_q <= sclk;
    end
  end

  // Shift stages known once twelve bits went in
  assign fill_d = (fill_q == 4'hc) ? fill_q : fill_q + 4'h1;

  always_ff @(posedge sclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      fill_q <= 4'h0;
    else
      fill_q <= fill_d;
  end

  a_load_sclk_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    load_strobe |-> !sclk) else $error("sclk high during load");
  a_load_width: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(load_strobe) |-> load_strobe[*4] ##1 !load_strobe) else $error("load width wrong");
  a_frame_count: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(load_strobe) |-> rise_q == 4'hc) else $error("load without twelve rises");
  a_sclk_high: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(sclk) |-> sclk[*3] ##1 !sclk) else $error("sclk high phase wrong");
  a_sclk_low: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(sclk) |-> !sclk[*3]) else $error("sclk low phase short");
  a_data_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    sclk && $past(sclk) |-> $stable(serial_in)) else $error("data moved with sclk high");
  a_load_gap: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(load_strobe) |-> !sclk[*8]) else $error("frame too soon after load");
  a_echo_delay: assert property (@(posedge sclk) disable iff (!i_rst_b)
    fill_q == 4'hc |-> serial_out == $past(serial_in, 12)) else $error("echo delay wrong");
endmodule // odl_link_properties

// ==== octal_dac_serial_load_port_tb.sv ====
// Purpose: Host end drives device end over the link; codes and echo checked
// Assumes: Expected codes kept in a bench model, queued per frame
// Notes:   Random codes from an LFSR seeded with 45
`timescale 1ns/10ps
`include "odl_map.svh"
module octal_dac_serial_load_port_tb;
  import odl_pkg::*;
  logic       i_clk;
  logic       i_rst_b;
  logic       i_req;
  odl_addr_t  i_addr;
  odl_code_t  i_code;
  logic       i_preset;
  logic       o_busy;
  logic       o_done;
  odl_frame_t o_echo;
  logic [63:0] o_codes;
  logic       o_update;
  odl_chan_t  o_update_chan;
  logic       o_nop;
  odl_addr_t  o_last_addr;
  logic [63:0] model;
  logic [71:0] q[$];
  logic [71:0] note;
  odl_chan_t  last_ch;
  logic [15:0] seed;
  odl_frame_t prev;
  logic       have_prev;
  int         err_total;
  int         num_checks;

  odl_link_if odl_link_if_inst ();

  odl_host_port odl_host_port_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req),
    .i_addr(i_addr), .i_code(i_code), .i_preset(i_preset), .link(odl_link_if_inst.host),
    .o_busy(o_busy), .o_done(o_done), .o_echo(o_echo));

  odl_dac_port odl_dac_port_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .link(odl_link_if_inst.dev), .o_codes(o_codes), .o_update(o_update),
    .o_update_chan(o_update_chan), .o_nop(o_nop), .o_last_addr(o_last_addr));

  odl_link_properties odl_link_properties_inst (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .sclk(odl_link_if_inst.sclk), .serial_in(odl_link_if_inst.serial_in),
    .load_strobe(odl_link_if_inst.load_strobe), .preset_n(odl_link_if_inst.preset_n),
    .serial_out(odl_link_if_inst.serial_out));

  always #5 i_clk = ~i_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string name, input logic [71:0] got, input logic [71:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One frame; the expected device result is queued before it is sent
  task automatic send(input odl_addr_t a, input odl_code_t c);
    int n;
    n = 0;
    if (a >= `ODL_ADDR_FIRST && a <= `ODL_ADDR_LAST)
    begin
      model[(a - 1) * 8 +: 8] = c;
      last_ch = 3'(a - 1);
      q.push_back({a, 1'b1, last_ch, model});
    end
    else
      q.push_back({a, 1'b0, last_ch, model});
    @(negedge i_clk);
    i_req = 1'b1;
    i_addr = a;
    i_code = c;
    @(negedge i_clk);
    i_req = 1'b0;
    check("busy", o_busy, 1'b1);
    while (o_done !== 1'b1 && n < 200)
    begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 200)
    begin
      err_total++;
      summarize();
    end
    else
    begin
      if (have_prev)
        check("echo", o_echo, prev);
      prev = {a, c};
      have_prev = 1'b1;
    end
  endtask

  // Every load result is matched against the oldest queued note
  always @(negedge i_clk)
  begin
    if (o_update === 1'b1 || o_nop === 1'b1)
    begin
      note = q.pop_front();
      check("update", o_update, note[67]);
      check("nop", o_nop, !note[67]);
      check("chan", o_update_chan, note[66:64]);
      check("codes", o_codes, note[63:0]);
      check("last_addr", o_last_addr, note[71:68]);
    end
  end

  initial
  begin
    i_clk = 1'b0;
    i_rst_b = 1'b0;
    i_req = 1'b0;
    i_addr = 4'h0;
    i_code = 8'h00;
    i_preset = 1'b0;
    have_prev = 1'b0;
    last_ch = 3'h0;
    seed = 16'h002d;
    model = {8{`ODL_PRESET_CODE}};
    repeat (16) @(negedge i_clk);
    i_rst_b = 1'b1;
    @(negedge i_clk);
    check("codes_after_reset", o_codes, model);
    for (int a = 0; a < 16; a++)
    begin
      seed = lfsr(seed);
      send(4'(a), seed[7:0]);
    end
    i_preset = 1'b1;
    repeat (3) @(negedge i_clk);
    model = {8{`ODL_PRESET_CODE}};
    check("codes_preset", o_codes, model);
    i_preset = 1'b0;
    repeat (2) @(negedge i_clk);
    for (int k = 0; k < 12; k++)
    begin
      seed = lfsr(seed);
      send(seed[11:8], seed[7:0]);
    end
    repeat (10) @(negedge i_clk);
    check("codes_hold", o_codes, model);
    check("pending", 72'(q.size()), 72'h0);
    summarize();
  end
endmodule // octal_dac_serial_load_port_tb
